//--- logic/sid_ar_mem.v
// Small register memory holding the four anti-resonance settings.
// Assumes one synchronous writer and registered reads on the decoder clock.
`timescale 1ns/1ps
`include "sid_defines.vh"
module sid_ar_mem #(
  parameter DEPTH = 4,
  parameter AW    = 2,
  parameter DW    = 32
) (
  input  wire          clk,
  input  wire          resetn,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr_a,
  output reg  [DW-1:0] rd_data_a,
  input  wire [AW-1:0] rd_addr_b,
  output reg  [DW-1:0] rd_data_b
);
  reg [DW-1:0] mem [0:DEPTH-1];
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      always @(posedge clk or negedge resetn) begin
        if (!resetn)
          mem[g] <= `SID_AR_RESET;
        else if (wr_en && wr_addr == g)
          mem[g] <= wr_data;
      end
    end
  endgenerate
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_a <= {DW{1'b0}};
      rd_data_b <= {DW{1'b0}};
    end else begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
    end
  end
endmodule // sid_ar_mem

//--- logic/sid_defines.vh
// Constants of the servo sequence input decoder: register map, fields, codes.
// Included by the decoder files; holds definitions only.
`ifndef SID_DEFINES_VH
`define SID_DEFINES_VH
`define SID_FN_COAST        8'h36
`define SID_FN_EDIT         8'h37
`define SID_FN_ARSEL0       8'h39
`define SID_FN_ARSEL1       8'h3a
`define SID_FN_ADDR0        8'h3c
`define SID_FN_START        8'h40
`define SID_FN_INTDATA      8'h4d
`define SID_OUTFN_EDIT_RESP 8'h1d
`define SID_AR_FREQ_OFF     16'h0bb8
`define SID_REG_ASSIGN_LO   8'h00
`define SID_REG_ASSIGN_HI   8'h04
`define SID_REG_CTRL        8'h08
`define SID_REG_AR_SET0     8'h10
`define SID_REG_STATUS      8'h20
`define SID_REG_IRQ_STAT    8'h24
`define SID_REG_IRQ_MASK    8'h28
`define SID_REG_SEL_AR      8'h2c
`define SID_REG_OUT_ASSIGN  8'h30
`define SID_CTRL_LOCK_BIT   0
`define SID_CTRL_INTEN_BIT  1
`define SID_CTRL_SEQ_LSB    4
`define SID_SEQ_ERROR       2'h0
`define SID_SEQ_SEQUENTIAL  2'h1
`define SID_SEQ_HOMING      2'h2
`define SID_ASSIGN_RESET    32'h00000000
`define SID_AR_RESET        32'h00000bb8
`define SID_EV_START        0
`define SID_EV_ADDR_ERR     1
`define SID_EV_COAST        2
`define SID_EV_HOMING       3
`endif

//--- logic/sid_seq_decoder.v
// Servo sequence input decoder: assignable input terminals, coast override,
// edit permission, anti-resonance set selection, positioning address decode.
// Assumes terminals are asynchronous pins; registers reached over AXI4-Lite.
`timescale 1ns/1ps
`include "sid_defines.vh"
module sid_seq_decoder #(
  parameter NTERM = 8
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [NTERM-1:0] assignable_seq_input,
  input  wire             power_enable_req,
  input  wire             mode_req_valid,
  input  wire [1:0]       mode_req,
  output wire             power_stage_enable,
  output wire             coast_request,
  output wire             edit_mode_allowed,
  output wire             test_mode_allowed,
  output wire             param_write_allowed,
  output wire             edit_perm_response,
  output reg  [15:0]      antires_freq,
  output reg  [15:0]      antires_inertia,
  output reg              antires_enable,
  output reg  [3:0]       pos_entry,
  output reg              pos_start,
  output reg              seq_start,
  output reg              homing_start,
  output reg              addr_error,
  output wire             irq,
  input  wire [7:0]       s_axi_awaddr,
  input  wire             s_axi_awvalid,
  output wire             s_axi_awready,
  input  wire [31:0]      s_axi_wdata,
  input  wire [3:0]       s_axi_wstrb,
  input  wire             s_axi_wvalid,
  output wire             s_axi_wready,
  output reg  [1:0]       s_axi_bresp,
  output reg              s_axi_bvalid,
  input  wire             s_axi_bready,
  input  wire [7:0]       s_axi_araddr,
  input  wire             s_axi_arvalid,
  output wire             s_axi_arready,
  output reg  [31:0]      s_axi_rdata,
  output reg  [1:0]       s_axi_rresp,
  output reg              s_axi_rvalid,
  input  wire             s_axi_rready
);
  localparam MODE_MONITOR = 2'h0;
  localparam MODE_EDIT    = 2'h1;
  localparam MODE_TEST    = 2'h2;

  reg  [NTERM-1:0] sync1;
  reg  [NTERM-1:0] sync2;
  reg  [7:0]       assign_code [0:NTERM-1];
  reg  [7:0]       out_assign;
  reg  [31:0]      ctrl;
  reg  [3:0]       irq_stat;
  reg  [3:0]       irq_mask;
  reg  [1:0]       op_mode;
  reg              start_d;
  reg              coast_d;
  reg  [7:0]       aw_addr;
  reg              aw_have;
  reg  [31:0]      w_data;
  reg              w_have;
  wire [31:0]      ar_rd;
  wire [31:0]      ar_sel_rd;
  wire [NTERM-1:0] hit_coast;
  wire [NTERM-1:0] hit_edit;
  wire [NTERM-1:0] hit_sel0;
  wire [NTERM-1:0] hit_sel1;
  wire [NTERM-1:0] hit_start;
  wire [NTERM-1:0] hit_int;
  wire [NTERM-1:0] hit_ad0;
  wire [NTERM-1:0] hit_ad1;
  wire [NTERM-1:0] hit_ad2;
  wire [NTERM-1:0] hit_ad3;
  wire [NTERM-1:0] asg_edit;
  reg  [3:0]       next_irq_set;
  integer          i;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1 <= {NTERM{1'b0}};
      sync2 <= {NTERM{1'b0}};
    end else begin
      sync1 <= assignable_seq_input;
      sync2 <= sync1;
    end
  end

  genvar t;
  generate
    for (t = 0; t < NTERM; t = t + 1) begin : g_term
      assign hit_coast[t] = sync2[t] && assign_code[t] == `SID_FN_COAST;
      assign asg_edit[t]  = assign_code[t] == `SID_FN_EDIT;
      assign hit_edit[t]  = sync2[t] && asg_edit[t];
      assign hit_sel0[t]  = sync2[t] && assign_code[t] == `SID_FN_ARSEL0;
      assign hit_sel1[t]  = sync2[t] && assign_code[t] == `SID_FN_ARSEL1;
      assign hit_start[t] = sync2[t] && assign_code[t] == `SID_FN_START;
      assign hit_int[t]   = sync2[t] && assign_code[t] == `SID_FN_INTDATA;
      assign hit_ad0[t]   = sync2[t] && assign_code[t] == `SID_FN_ADDR0;
      assign hit_ad1[t]   = sync2[t] && assign_code[t] == `SID_FN_ADDR0 + 8'h01;
      assign hit_ad2[t]   = sync2[t] && assign_code[t] == `SID_FN_ADDR0 + 8'h02;
      assign hit_ad3[t]   = sync2[t] && assign_code[t] == `SID_FN_ADDR0 + 8'h03;
    end
  endgenerate

  wire       f_coast = |hit_coast;
  wire       f_edit  = |hit_edit;
  wire       edit_assigned = |asg_edit;
  wire       f_start = |hit_start;
  wire       f_int   = |hit_int;
  wire [1:0] f_sel   = {|hit_sel1, |hit_sel0};
  wire [3:0] f_addr  = {|hit_ad3, |hit_ad2, |hit_ad1, |hit_ad0};
  wire       perm    = f_edit || !edit_assigned;
  wire       lock    = ctrl[`SID_CTRL_LOCK_BIT];

  assign coast_request = f_coast;
  assign power_stage_enable = power_enable_req && !f_coast;
  assign edit_mode_allowed = f_edit || !edit_assigned;
  assign test_mode_allowed = f_edit || !edit_assigned;
  assign param_write_allowed = perm && !lock;
  assign edit_perm_response = out_assign == `SID_OUTFN_EDIT_RESP && f_edit;

  // Operating mode held by keypad or loader_tool requests.
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      op_mode <= MODE_MONITOR;
    else if (!edit_mode_allowed)
      op_mode <= MODE_MONITOR;
    else if (mode_req_valid)
      op_mode <= (mode_req == MODE_EDIT || mode_req == MODE_TEST) ? mode_req : MODE_MONITOR;
  end

  // Address taken at start rising edge from the current decoded bits.
  wire start_rise = f_start && !start_d;
  wire [1:0] seq_sel = ctrl[`SID_CTRL_SEQ_LSB+1:`SID_CTRL_SEQ_LSB];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      start_d      <= 1'b0;
      coast_d      <= 1'b0;
      pos_entry    <= 4'h0;
      pos_start    <= 1'b0;
      seq_start    <= 1'b0;
      homing_start <= 1'b0;
      addr_error   <= 1'b0;
    end else begin
      start_d      <= f_start;
      coast_d      <= f_coast;
      pos_start    <= 1'b0;
      seq_start    <= 1'b0;
      homing_start <= 1'b0;
      addr_error   <= 1'b0;
      if (start_rise && ctrl[`SID_CTRL_INTEN_BIT] && f_int) begin
        pos_entry <= f_addr;
        if (f_addr != 4'h0)
          pos_start <= 1'b1;
        else if (seq_sel == `SID_SEQ_SEQUENTIAL)
          seq_start <= 1'b1;
        else if (seq_sel == `SID_SEQ_HOMING)
          homing_start <= 1'b1;
        else
          addr_error <= 1'b1;
      end
    end
  end

  // Pick set by select bits; host changes them only at standstill.
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire ar_wr   = wr_fire && (aw_addr & 8'hf0) == `SID_REG_AR_SET0;
  sid_ar_mem #(.DEPTH(4), .AW(2), .DW(32)) u_mem (
    .clk       (clk),
    .resetn    (resetn),
    .wr_en     (ar_wr),
    .wr_addr   (aw_addr[3:2]),
    .wr_data   (w_data),
    .rd_addr_a (f_sel),
    .rd_data_a (ar_sel_rd),
    .rd_addr_b (s_axi_araddr[3:2]),
    .rd_data_b (ar_rd)
  );
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      antires_freq    <= 16'h0000;
      antires_inertia <= 16'h0000;
      antires_enable  <= 1'b0;
    end else begin
      antires_freq    <= ar_sel_rd[15:0];
      antires_inertia <= ar_sel_rd[31:16];
      antires_enable  <= ar_sel_rd[15:0] != `SID_AR_FREQ_OFF;
    end
  end

  // Events: start taken, address error, coast onset, homing.
  always @* begin
    next_irq_set = 4'h0;
    next_irq_set[`SID_EV_START]    = pos_start | seq_start;
    next_irq_set[`SID_EV_ADDR_ERR] = addr_error;
    next_irq_set[`SID_EV_COAST]    = f_coast && !coast_d;
    next_irq_set[`SID_EV_HOMING]   = homing_start;
  end
  assign irq = |(irq_stat & irq_mask);

  // AXI4-Lite write side; address and data accepted in either order.
  assign s_axi_awready = !aw_have;
  assign s_axi_wready  = !w_have;
  wire wmapped = aw_addr == `SID_REG_ASSIGN_LO || aw_addr == `SID_REG_ASSIGN_HI ||
                 aw_addr == `SID_REG_CTRL || aw_addr == `SID_REG_IRQ_STAT ||
                 aw_addr == `SID_REG_IRQ_MASK || aw_addr == `SID_REG_OUT_ASSIGN || ar_wr;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      ctrl         <= 32'h00000000;
      irq_mask     <= 4'h0;
      irq_stat     <= 4'h0;
      out_assign   <= 8'h00;
      for (i = 0; i < NTERM; i = i + 1)
        assign_code[i] <= 8'h00;
    end else begin
      if (s_axi_awvalid && !aw_have) begin
        aw_have <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_have) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Hardware set wins over a same-cycle write-one clear.
      irq_stat <= irq_stat | next_irq_set;
      if (wr_fire) begin
        aw_have      <= 1'b0;
        w_have       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmapped ? 2'h0 : 2'h2;
        for (i = 0; i < NTERM; i = i + 1)
          if (aw_addr == (i < 4 ? `SID_REG_ASSIGN_LO : `SID_REG_ASSIGN_HI))
            assign_code[i] <= w_data[(i%4)*8 +: 8];
        if (aw_addr == `SID_REG_CTRL)
          ctrl <= w_data & 32'h00000033;
        if (aw_addr == `SID_REG_IRQ_MASK)
          irq_mask <= w_data[3:0];
        if (aw_addr == `SID_REG_OUT_ASSIGN)
          out_assign <= w_data[7:0];
        if (aw_addr == `SID_REG_IRQ_STAT)
          irq_stat <= (irq_stat & ~w_data[3:0]) | next_irq_set;
      end
    end
  end

  // AXI4-Lite read side; registers answer one cycle after the address is taken and
  // the set memory two, so rdata never changes while rvalid stands.
  reg        rd_mem;
  assign s_axi_arready = !s_axi_rvalid && !rd_mem;
  reg [31:0] rmux;
  reg        rok;
  reg [7:0]  ra;
  always @* begin
    ra   = {s_axi_araddr[7:2], 2'b00};
    rok  = 1'b1;
    rmux = 32'h00000000;
    case (ra)
      `SID_REG_ASSIGN_LO:  rmux = {assign_code[3], assign_code[2], assign_code[1], assign_code[0]};
      `SID_REG_ASSIGN_HI:  rmux = {assign_code[7], assign_code[6], assign_code[5], assign_code[4]};
      `SID_REG_CTRL:       rmux = ctrl;
      `SID_REG_STATUS:     rmux = {20'h00000, f_sel, op_mode, f_addr,
                                   param_write_allowed, f_edit, f_start, f_coast};
      `SID_REG_IRQ_STAT:   rmux = {28'h0000000, irq_stat};
      `SID_REG_IRQ_MASK:   rmux = {28'h0000000, irq_mask};
      `SID_REG_SEL_AR:     rmux = ar_sel_rd;
      `SID_REG_OUT_ASSIGN: rmux = {24'h000000, out_assign};
      default:             rok  = ra[7:4] == 4'h1;
    endcase
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
      rd_mem       <= 1'b0;
    end else if (rd_mem) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= ar_rd;
      rd_mem       <= 1'b0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= ra[7:4] != 4'h1;
      s_axi_rdata  <= rmux;
      s_axi_rresp  <= rok ? 2'h0 : 2'h2;
      rd_mem       <= ra[7:4] == 4'h1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // sid_seq_decoder

//--- testbench/sid_host_model.sv
// Host sequence controller model: drives the terminals from a wanted pattern.
// Assumes the bench sets the pattern at rising edges and shows the power state.
`timescale 1ns/1ps
module sid_host_model #(
  parameter SEL_LSB = 2
) (
  input  wire       clk,
  input  wire       resetn,
  input  wire       moving,
  input  wire [7:0] want,
  output reg  [7:0] term
);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      term <= 8'h00;
    end else begin
      term <= want;
      if (moving) term[SEL_LSB +: 2] <= term[SEL_LSB +: 2];
    end
  end
endmodule // sid_host_model

//--- testbench/sid_seq_decoder_chk.sv
// Checker for the sequence decoder: output relations seen at its ports only.
// Assumes one clock domain and the active-low reset of the decoder.
`timescale 1ns/1ps
`include "sid_defines.vh"
module sid_seq_decoder_chk (
  input wire        clk,
  input wire        resetn,
  input wire        power_enable_req,
  input wire        power_stage_enable,
  input wire        coast_request,
  input wire        edit_mode_allowed,
  input wire        test_mode_allowed,
  input wire        param_write_allowed,
  input wire        edit_perm_response,
  input wire [15:0] antires_freq,
  input wire        antires_enable,
  input wire [3:0]  pos_entry,
  input wire        pos_start,
  input wire        seq_start,
  input wire        homing_start,
  input wire        addr_error
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_coast_kills_power: assert property (coast_request |-> !power_stage_enable)
    else $error("power on during coast");
  a_power_follows_req: assert property (power_enable_req && !coast_request |-> power_stage_enable)
    else $error("power off without coast");
  a_edit_test_pair: assert property (edit_mode_allowed == test_mode_allowed)
    else $error("edit and test permission differ");
  a_write_needs_edit: assert property (param_write_allowed |-> edit_mode_allowed)
    else $error("write allowed without edit permission");
  a_resp_needs_edit: assert property (edit_perm_response |-> edit_mode_allowed)
    else $error("response without edit permission");
  a_off_freq_disables: assert property (antires_freq == `SID_AR_FREQ_OFF |-> !antires_enable)
    else $error("suppression on at off frequency");
  a_start_one_pulse: assert property (pos_start |=> !pos_start)
    else $error("start pulse too long");
  a_one_start_kind: assert property ($onehot0({pos_start, seq_start, homing_start, addr_error}))
    else $error("two start kinds at once");
  a_zero_addr_kinds: assert property (seq_start || homing_start || addr_error |-> pos_entry == 4'h0)
    else $error("address zero action on nonzero entry");
  a_entry_nonzero: assert property (pos_start |-> pos_entry != 4'h0)
    else $error("data start on entry zero");
  c_coast: cover property (coast_request);
  c_homing: cover property (homing_start);
  c_addr_err: cover property (addr_error);
endmodule // sid_seq_decoder_chk
bind sid_seq_decoder sid_seq_decoder_chk i_sid_seq_decoder_chk (
  .clk(clk), .resetn(resetn), .power_enable_req(power_enable_req),
  .power_stage_enable(power_stage_enable), .coast_request(coast_request),
  .edit_mode_allowed(edit_mode_allowed), .test_mode_allowed(test_mode_allowed),
  .param_write_allowed(param_write_allowed), .edit_perm_response(edit_perm_response),
  .antires_freq(antires_freq), .antires_enable(antires_enable), .pos_entry(pos_entry),
  .pos_start(pos_start), .seq_start(seq_start), .homing_start(homing_start),
  .addr_error(addr_error));

//--- testbench/sid_seq_decoder_tb.sv
// Bench for the sequence decoder: AXI4-Lite register tasks and terminal scenarios.
// Assumes the host model drives the terminals and the checker is bound.
`timescale 1ns/1ps
`include "sid_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module sid_seq_decoder_tb;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         pwr = 1'b0;
  reg  [7:0]  want = 8'h00;
  reg  [7:0]  awa = 8'h00;
  reg  [7:0]  ara = 8'h00;
  reg  [31:0] wd = 32'h0;
  reg         awv = 1'b0;
  reg         wv = 1'b0;
  reg         arv = 1'b0;
  reg         mrv = 1'b0;
  reg  [1:0]  mr = 2'h0;
  wire [7:0]  term;
  wire        pse, coast, edm, tsm, pwa, epr, aen, ps, ss, hs, ae, irq;
  wire        awr, wr, bv, arr, rv;
  wire [15:0] af, ai;
  wire [3:0]  pe;
  wire [1:0]  br, rr;
  wire [31:0] rd;
  integer     errors = 0;
  integer     samples_checked = 0;
  integer     i, n;
  reg  [8:0]  q;
  reg  [3:0]  ad;
  reg  [15:0] f;
  sid_host_model i_sid_host_model (.clk(clk), .resetn(resetn), .moving(pse), .want(want),
    .term(term));
  sid_seq_decoder i_sid_seq_decoder (.clk(clk), .resetn(resetn), .assignable_seq_input(term),
    .power_enable_req(pwr), .mode_req_valid(mrv), .mode_req(mr),
    .power_stage_enable(pse), .coast_request(coast), .edit_mode_allowed(edm),
    .test_mode_allowed(tsm), .param_write_allowed(pwa), .edit_perm_response(epr),
    .antires_freq(af), .antires_inertia(ai), .antires_enable(aen), .pos_entry(pe),
    .pos_start(ps), .seq_start(ss), .homing_start(hs), .addr_error(ae), .irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(1'b1));
  initial forever #12.5 clk = ~clk;
  task print_verdict;
    begin
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task hang;
    begin
      errors++;
      print_verdict;
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge clk);
  endtask
  // Handshakes are judged at the falling edge and released after the next rising edge.
  task axw(input [7:0] a, input [31:0] d, input [1:0] e);
    integer k;
    reg ta, tw, b;
    reg [1:0] r;
    begin
      b = 0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      for (k = 0; k < 40 && !b; k++) begin
        @(negedge clk);
        ta = awv & awr;
        tw = wv & wr;
        b = bv;
        r = br;
        @(posedge clk);
        if (ta) awv <= 1'b0;
        if (tw) wv <= 1'b0;
      end
      if (!b) hang;
      `CHK(r, e)
    end
  endtask
  // Read data are taken at the first edge at which rvalid stands.
  task axr(input [7:0] a, input [31:0] d, input [1:0] e);
    integer k;
    reg t, g;
    reg [31:0] x;
    reg [1:0] r;
    begin
      g = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      for (k = 0; k < 40 && !g; k++) begin
        @(negedge clk);
        t = arv & arr;
        if (rv) begin
          g = 1;
          x = rd;
          r = rr;
        end
        @(posedge clk);
        if (t) arv <= 1'b0;
      end
      if (!g) hang;
      `CHK(x, d)
      `CHK(r, e)
    end
  endtask
  initial begin
    wt(5);
    resetn <= 1'b1;
    axr(`SID_REG_ASSIGN_LO, `SID_ASSIGN_RESET, 2'h0);
    axr(`SID_REG_AR_SET0, `SID_AR_RESET, 2'h0);
    axr(8'h34, 32'h0, 2'h2);
    axw(8'h34, 32'h1, 2'h2);
    want <= 8'hff;
    pwr <= 1'b1;
    wt(6);
    `CHK({coast, pse, edm, pwa, epr}, 5'b01110)
    axw(`SID_REG_ASSIGN_LO, 32'h3a393736, 2'h0);
    want <= 8'h0e;
    wt(6);
    `CHK({coast, pse, edm}, 3'b011)
    want <= 8'h0f;
    wt(6);
    `CHK({coast, pse}, 2'b10)
    want <= 8'h0c;
    wt(6);
    `CHK({edm, tsm, pwa}, 3'b000)
    mrv <= 1'b1;
    mr <= 2'h1;
    @(posedge clk);
    mrv <= 1'b0;
    axr(`SID_REG_STATUS, 32'h00000c00, 2'h0);
    axw(`SID_REG_OUT_ASSIGN, 32'h1d, 2'h0);
    want <= 8'h0e;
    wt(6);
    `CHK({epr, pwa, tsm}, 3'b111)
    mrv <= 1'b1;
    @(posedge clk);
    mrv <= 1'b0;
    axr(`SID_REG_STATUS, 32'h00000d0c, 2'h0);
    axw(`SID_REG_CTRL, 32'h1, 2'h0);
    wt(2);
    `CHK({pwa, edm}, 2'b01)
    axw(`SID_REG_CTRL, 32'h0, 2'h0);
    for (i = 0; i < 4; i++) begin
      f = (i == 3) ? `SID_AR_FREQ_OFF : 16'h0200 + i[15:0];
      axw(`SID_REG_AR_SET0 + 8'h04 * i[7:0], {16'h0100 + i[15:0], f}, 2'h0);
    end
    pwr <= 1'b0;
    for (i = 0; i < 4; i++) begin
      f = (i == 3) ? `SID_AR_FREQ_OFF : 16'h0200 + i[15:0];
      want <= {4'h0, i[1:0], 2'b10};
      wt(8);
      `CHK({af, ai, aen}, {f, 16'h0100 + i[15:0], i != 3})
    end
    axw(`SID_REG_ASSIGN_LO, 32'h4d403736, 2'h0);
    axw(`SID_REG_ASSIGN_HI, 32'h3f3e3d3c, 2'h0);
    axw(`SID_REG_IRQ_MASK, 32'h2, 2'h0);
    for (i = 0; i < 5; i++) begin
      ad = (i < 3) ? 4'h0 : ((i == 3) ? 4'h5 : 4'hf);
      axw(`SID_REG_CTRL, ((i % 3) << 4) | 2, 2'h0);
      want <= {~ad, 4'b1010};
      wt(4);
      want <= {ad, 4'b1110};
      q = 9'h0;
      for (n = 0; n < 20 && !q[8]; n++) begin
        @(negedge clk);
        if (ps | ss | hs | ae) q = {1'b1, pe, hs, ss, ae, ps};
      end
      if (!q[8]) hang;
      `CHK(q[7:0], {ad, (i < 3) ? 4'b0010 << i : 4'b0001})
      @(posedge clk);
      want <= {ad, 4'b1010};
      wt(4);
      if (i == 0) begin
        `CHK(irq, 1'b1)
        axw(`SID_REG_IRQ_STAT, 32'hf, 2'h0);
        wt(2);
        `CHK(irq, 1'b0)
      end
    end
    `CHK(irq, 1'b0)
    print_verdict;
  end
endmodule // sid_seq_decoder_tb
